// ---- cpu_bus_pkg.sv ----
// constants and types shared by the front-side bus block
package cpu_bus_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] CMD_OFS   = 8'h04;
    localparam logic [7:0] ADDR_OFS  = 8'h08;
    localparam logic [7:0] WLO_OFS   = 8'h0C;
    localparam logic [7:0] WHI_OFS   = 8'h10;
    localparam logic [7:0] RLO_OFS   = 8'h14;
    localparam logic [7:0] RHI_OFS   = 8'h18;
    localparam logic [7:0] STAT_OFS  = 8'h1C;
    localparam logic [7:0] SNOOP_OFS = 8'h20;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_PAGING = 0;
    localparam int CTRL_SMM    = 1;
    localparam int CTRL_LOCK   = 2;
    localparam int CTRL_WB     = 3;
    localparam int CMD_GO      = 8;
    localparam int CMD_BUSY    = 8;
    localparam int STAT_SPEED  = 4;
    localparam int STAT_STRAP  = 6;
    localparam int STAT_VOLT   = 7;
    localparam int STAT_BUSY   = 12;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [4:0] CMD_RST  = 5'h00;

    // ------------------------------------------------------------
    // request command codes
    // ------------------------------------------------------------
    localparam logic [4:0] REQ_DEFER = 5'h00;
    localparam logic [4:0] REQ_INTA  = 5'h08;
    localparam logic [4:0] REQ_IORD  = 5'h10;
    localparam logic [4:0] REQ_IOWR  = 5'h11;

    typedef enum logic [1:0] {
        SPEED_66,
        SPEED_100,
        SPEED_133
    } bus_speed_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARB,
        ST_REQ,
        ST_HOLD,
        ST_DATA
    } bus_state_type;

endpackage

// ---- cpu_bus_front.sv ----
// front-side bus request side with reset straps and voltage code
// How it works
// - latch four ratio straps at reset release
// - straps used only when ratio select low
// - decode strap pattern into ratio 2.5 to 7.5
// - voltage pins pull low or float high
// - drive fixed voltage code on five pins
// - bus speed from two selects during reset
// - reset aborts everything, outputs to reset values
// - address lines drive, receive; I/O upper zero
// - mask input forces address bit 20 low
// - no bit-20 mask for exempt accesses
// - drive data lines only during own writes
// - transactions pass phases in fixed order
// - yield to priority agent request
// - block-next-request stalls the next transaction
// - hold lock through non-interruptible sequences
// - strobe starts request; lines valid two clocks
// - request command encoding on five lines
// - everything but the async reset timed on rising bus clock edge
`timescale 1ns/1ps

module cpu_bus_front
    import cpu_bus_pkg::*;
#(
    parameter logic [3:0] DEFAULT_RATIO_X2 = 4'h6,
    parameter logic [4:0] VOLTAGE_CODE     = 5'h1D
) (
    input  wire logic        ref_clk_i,     // bus clock
    input  wire logic        resetn_i,      // async reset, low
    input  wire logic [7:0]  paddr_i,       // apb address
    input  wire logic        psel_i,        // apb select
    input  wire logic        penable_i,     // apb enable
    input  wire logic        pwrite_i,      // apb direction
    input  wire logic [31:0] pwdata_i,      // apb write data
    output logic [31:0]      prdata_o,      // apb read data
    output logic             pready_o,      // apb ready
    output logic             pslverr_o,     // apb error
    input  wire logic        nmi_i,         // ratio strap 3
    input  wire logic        maskable_interrupt_in_i,     // strap 2
    input  wire logic        address_bit20_mask_n_i,      // strap 1
    input  wire logic        ignore_numeric_error_n_i,    // strap 0
    input  wire logic        external_ratio_select_n_i,   // strap use
    input  wire logic        bus_speed_select0_i,         // speed sel
    input  wire logic        bus_speed_select1_i,         // speed sel
    output logic [4:0]       voltage_code_out_o,    // pin level
    output logic [4:0]       voltage_code_out_oe_o, // pull low
    input  wire logic [31:3] addr_in_i,     // address pins in
    output logic [31:3]      addr_out_o,    // address pins out
    output logic             addr_oe_o,     // address drive
    input  wire logic [63:0] data_in_i,     // data pins in
    output logic [63:0]      data_out_o,    // data pins out
    output logic             data_oe_o,     // data drive
    output logic [4:0]       req_out_o,     // request command
    output logic             req_oe_o,      // request drive
    input  wire logic        address_strobe_n_i,   // strobe in
    output logic             address_strobe_n_o,   // strobe out
    output logic             address_strobe_oe_o,  // strobe drive
    input  wire logic        priority_agent_request_n_i, // chipset
    input  wire logic        block_next_request_n_i,     // stall
    output logic             lock_n_o,      // lock level
    output logic             lock_oe_o      // lock drive
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // ratio in half steps; zero marks an unsupported pattern
    function automatic logic [3:0] ratio_decode(input logic [3:0] s);
        case (s)
            4'h4:    ratio_decode = 4'h5;
            4'h1:    ratio_decode = 4'h6;
            4'h5:    ratio_decode = 4'h7;
            4'h2:    ratio_decode = 4'h8;
            4'h6:    ratio_decode = 4'h9;
            4'h3:    ratio_decode = 4'hA;
            4'h7:    ratio_decode = 4'hB;
            4'h8:    ratio_decode = 4'hC;
            4'hC:    ratio_decode = 4'hD;
            4'h9:    ratio_decode = 4'hE;
            4'hD:    ratio_decode = 4'hF;
            default: ratio_decode = 4'h0;
        endcase
    endfunction

    function automatic logic cmd_valid(input logic [4:0] c);
        cmd_valid = (c == REQ_DEFER) || (c == REQ_INTA) ||
                    (c == REQ_IORD) || (c == REQ_IOWR) ||
                    (c[2:0] == 3'h2) || (c[2]);
    endfunction

    function automatic logic cmd_write(input logic [4:0] c);
        cmd_write = (c == REQ_IOWR) || (c[2:0] == 3'h5) ||
                    (c[2:0] == 3'h7);
    endfunction

    function automatic logic cmd_io(input logic [4:0] c);
        cmd_io = (c == REQ_IORD) || (c == REQ_IOWR);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic          capture_pend;
    logic [3:0]    ratio_x2;
    logic          strap_used;
    bus_speed_type bus_speed;
    logic [3:0]    ctrl;
    logic [4:0]    cmd;
    logic [31:3]   addr_reg;
    logic [63:0]   wdata;
    logic [63:0]   rdata;
    logic [31:3]   snoop_addr;
    bus_state_type state;
    logic          go;
    logic          a20_masked;
    logic [31:3]   next_addr;
    logic [31:0]   next_prdata;
    logic          next_err;
    logic          apb_wr;
    logic [3:0]    strap;

    assign strap  = {nmi_i, maskable_interrupt_in_i,
                     address_bit20_mask_n_i, ignore_numeric_error_n_i};
    assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    assign go     = apb_wr && (paddr_i == CMD_OFS) &&
                    pwdata_i[CMD_GO] && cmd_valid(pwdata_i[4:0]);

    // ------------------------------------------------------------
    // reset straps
    // ------------------------------------------------------------
    // async reset may not load a pin, so the first edge after
    // release takes the straps; they are stable long before it
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            capture_pend <= 1'b1;
            ratio_x2     <= DEFAULT_RATIO_X2;
            strap_used   <= 1'b0;
            bus_speed    <= SPEED_66;
        end else if (capture_pend) begin
            capture_pend <= 1'b0;
            if (!external_ratio_select_n_i &&
                ratio_decode(strap) != 4'h0) begin
                ratio_x2   <= ratio_decode(strap);
                strap_used <= 1'b1;
            end
            if (!bus_speed_select0_i) begin
                bus_speed <= SPEED_66;
            end else if (!bus_speed_select1_i) begin
                bus_speed <= SPEED_100;
            end else begin
                bus_speed <= SPEED_133;
            end
        end
    end

    // open-drain pins: enable pulls low, a one leaves it open
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            voltage_code_out_o    <= 5'h00;
            voltage_code_out_oe_o <= ~VOLTAGE_CODE;
        end else begin
            voltage_code_out_o    <= 5'h00;
            voltage_code_out_oe_o <= ~VOLTAGE_CODE;
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    always_comb begin
        next_err    = 1'b0;
        next_prdata = 32'h0000_0000;
        if (paddr_i == CTRL_OFS) begin
            next_prdata[3:0] = ctrl;
        end else if (paddr_i == CMD_OFS) begin
            next_prdata[4:0]      = cmd;
            next_prdata[CMD_BUSY] = (state != ST_IDLE);
        end else if (paddr_i == ADDR_OFS) begin
            next_prdata[31:3] = addr_reg;
        end else if (paddr_i == WLO_OFS) begin
            next_prdata = wdata[31:0];
        end else if (paddr_i == WHI_OFS) begin
            next_prdata = wdata[63:32];
        end else if (paddr_i == RLO_OFS) begin
            next_prdata = rdata[31:0];
        end else if (paddr_i == RHI_OFS) begin
            next_prdata = rdata[63:32];
        end else if (paddr_i == STAT_OFS) begin
            next_prdata[3:0]             = ratio_x2;
            next_prdata[STAT_SPEED+:2]   = bus_speed;
            next_prdata[STAT_STRAP]      = strap_used;
            next_prdata[STAT_VOLT+:5]    = VOLTAGE_CODE;
            next_prdata[STAT_BUSY]       = (state != ST_IDLE);
        end else if (paddr_i == SNOOP_OFS) begin
            next_prdata[31:3] = snoop_addr;
        end else begin
            next_err = 1'b1;
        end
    end

    // answer is prepared in setup, so access never waits
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & next_err;
            prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ?
                         next_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl     <= CTRL_RST;
            cmd      <= CMD_RST;
            addr_reg <= '0;
            wdata    <= '0;
        end else if (apb_wr) begin
            if (paddr_i == CTRL_OFS) begin
                ctrl <= pwdata_i[3:0];
            end else if (paddr_i == ADDR_OFS && state == ST_IDLE) begin
                addr_reg <= pwdata_i[31:3];
            end else if (paddr_i == WLO_OFS && state == ST_IDLE) begin
                wdata[31:0] <= pwdata_i;
            end else if (paddr_i == WHI_OFS && state == ST_IDLE) begin
                wdata[63:32] <= pwdata_i;
            end else if (go && state == ST_IDLE) begin
                cmd <= pwdata_i[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // address shaping
    // ------------------------------------------------------------
    // write-back, smm and paged accesses are never masked
    assign a20_masked = ~address_bit20_mask_n_i & ~ctrl[CTRL_PAGING] &
                        ~ctrl[CTRL_SMM] & ~ctrl[CTRL_WB];

    always_comb begin
        next_addr = addr_reg;
        if (cmd_io(cmd)) begin
            next_addr[31:16] = 16'h0000;
        end
        if (a20_masked) begin
            next_addr[20] = 1'b0;
        end
    end

    // inquiry address from the system while not driving
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snoop_addr <= '0;
        end else if (!address_strobe_n_i && !address_strobe_oe_o) begin
            snoop_addr <= addr_in_i;
        end
    end

    // ------------------------------------------------------------
    // arbitration and request sequence
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state               <= ST_IDLE;
            address_strobe_n_o  <= 1'b1;
            address_strobe_oe_o <= 1'b0;
            addr_out_o          <= '0;
            addr_oe_o           <= 1'b0;
            req_out_o           <= 5'h00;
            req_oe_o            <= 1'b0;
            data_out_o          <= '0;
            data_oe_o           <= 1'b0;
            rdata               <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go) begin
                        state <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    if (priority_agent_request_n_i &&
                        block_next_request_n_i) begin
                        state               <= ST_REQ;
                        address_strobe_n_o  <= 1'b0;
                        address_strobe_oe_o <= 1'b1;
                        addr_out_o          <= next_addr;
                        addr_oe_o           <= 1'b1;
                        req_out_o           <= cmd;
                        req_oe_o            <= 1'b1;
                    end
                end
                ST_REQ: begin
                    state              <= ST_HOLD;
                    address_strobe_n_o <= 1'b1;
                end
                ST_HOLD: begin
                    state               <= ST_DATA;
                    address_strobe_oe_o <= 1'b0;
                    addr_oe_o           <= 1'b0;
                    req_oe_o            <= 1'b0;
                    if (cmd_write(cmd)) begin
                        data_out_o <= wdata;
                        data_oe_o  <= 1'b1;
                    end
                end
                default: begin
                    state     <= ST_IDLE;
                    data_oe_o <= 1'b0;
                    if (!cmd_write(cmd)) begin
                        rdata <= data_in_i;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_n_o  <= 1'b1;
            lock_oe_o <= 1'b0;
        end else begin
            lock_n_o  <= ~ctrl[CTRL_LOCK];
            lock_oe_o <= ctrl[CTRL_LOCK];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_strobe;
        $fell(address_strobe_n_o);
    endsequence

    a_req_held: assert property (s_strobe |=>
        $stable(addr_out_o) && $stable(req_out_o) && addr_oe_o)
        else $error("request lines changed during strobe window");
    a_prio_yield: assert property (s_strobe |->
        $past(priority_agent_request_n_i))
        else $error("strobe started under priority request");
    a_block_stall: assert property (s_strobe |->
        $past(block_next_request_n_i))
        else $error("strobe started under block next request");
    a_data_drive: assert property (data_oe_o |->
        state == ST_DATA && cmd_write(req_out_o))
        else $error("data driven outside own write");
    a_io_upper: assert property (addr_oe_o && cmd_io(req_out_o) |->
        addr_out_o[31:16] == 16'h0000)
        else $error("upper address not low on io access");
    a_a20_force: assert property (s_strobe and $past(a20_masked) |->
        !addr_out_o[20])
        else $error("bit 20 not masked");
    a_a20_exempt: assert property (s_strobe and
        $past(ctrl[CTRL_PAGING]) |-> addr_out_o[20] == addr_reg[20])
        else $error("bit 20 masked while paging");
    a_strap_hold: assert property (!capture_pend &&
        !$past(capture_pend) |-> $stable(ratio_x2) && $stable(bus_speed))
        else $error("captured straps changed");
    a_ratio_dflt: assert property ($fell(capture_pend) &&
        $past(external_ratio_select_n_i) |-> ratio_x2 == DEFAULT_RATIO_X2)
        else $error("default ratio not used");
    a_volt_fixed: assert property (voltage_code_out_oe_o ==
        ~VOLTAGE_CODE && voltage_code_out_o == 5'h00)
        else $error("voltage code wrong");

endmodule

// ---- chipset_model.sv ----
// chipset side of the front-side bus, used by the bench
`timescale 1ns/1ps

module chipset_model #(
    parameter logic [63:0] READ_WORD = 64'h0123_4567_89AB_CDEF
) (
    input  wire logic        ref_clk_i,    // bus clock
    input  wire logic        resetn_i,     // async reset, low
    input  wire logic        hold_pri_i,   // claim priority
    input  wire logic        hold_blk_i,   // stall next request
    input  wire logic        snoop_i,      // run an inquiry
    input  wire logic [31:3] snoop_addr_i, // inquiry address
    input  wire logic [31:3] addr_out_i,   // device address
    input  wire logic        addr_oe_i,    // device address drive
    input  wire logic [63:0] data_out_i,   // device data
    input  wire logic        data_oe_i,    // device data drive
    input  wire logic        strobe_n_i,   // device strobe
    input  wire logic        strobe_oe_i,  // device strobe drive
    output logic [31:3]      addr_o,       // address wire
    output logic [63:0]      data_o,       // data wire
    output logic             strobe_n_o,   // strobe wire
    output logic             pri_n_o,      // priority request
    output logic             blk_n_o       // block next request
);
    logic [1:0] phase;
    logic       tick;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= 2'h0;
            tick  <= 1'b0;
        end else begin
            tick <= ~tick;
            if (strobe_oe_i && !strobe_n_i) begin
                phase <= 2'h1;
            end else if (phase != 2'h0) begin
                phase <= phase + 2'h1;
            end
        end
    end

    assign pri_n_o    = ~hold_pri_i;
    assign blk_n_o    = ~hold_blk_i;
    assign strobe_n_o = strobe_oe_i ? strobe_n_i : ~snoop_i;
    // released lines toggle so a stale value never reads as valid
    assign addr_o = addr_oe_i ? addr_out_i
                  : (snoop_i ? snoop_addr_i : {29{tick}});
    assign data_o = data_oe_i ? data_out_i
                  : (phase == 2'h2 ? READ_WORD : {64{tick}});
endmodule

// ---- tb_top.sv ----
// self-checking bench for the front-side bus request block
`timescale 1ns/1ps

module tb_top
    import cpu_bus_pkg::*;
;
    localparam logic [4:0]  VC  = 5'h1D;
    localparam logic [31:0] A   = 32'h8012_3458;
    localparam logic [31:0] M20 = 32'hFFEF_FFFF;
    localparam logic [31:0] WL  = 32'hA5A5_0F0F;
    localparam logic [31:0] WH  = 32'h1234_5678;
    localparam logic [63:0] RW  = 64'h0123_4567_89AB_CDEF;

    logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  straps;
    logic        ext_n, bs0, bs1, addr_oe, data_oe, req_oe;
    logic        strb_in, strb_o, strb_oe, pri_n, blk_n, lock_n, lock_oe;
    logic        hold_pri, hold_blk, snoop;
    logic [4:0]  vlt, vlt_oe, req;
    logic [31:3] addr_in, addr_out, snoop_addr;
    logic [63:0] data_in, data_out;
    int          fail_count = 0;
    int          samples_checked = 0;

    cpu_bus_front #(.VOLTAGE_CODE(VC)) dut_u (
        .ref_clk_i(clk), .resetn_i(rstn), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .nmi_i(straps[3]),
        .maskable_interrupt_in_i(straps[2]),
        .address_bit20_mask_n_i(straps[1]),
        .ignore_numeric_error_n_i(straps[0]),
        .external_ratio_select_n_i(ext_n),
        .bus_speed_select0_i(bs0), .bus_speed_select1_i(bs1),
        .voltage_code_out_o(vlt), .voltage_code_out_oe_o(vlt_oe),
        .addr_in_i(addr_in), .addr_out_o(addr_out), .addr_oe_o(addr_oe),
        .data_in_i(data_in), .data_out_o(data_out), .data_oe_o(data_oe),
        .req_out_o(req), .req_oe_o(req_oe),
        .address_strobe_n_i(strb_in), .address_strobe_n_o(strb_o),
        .address_strobe_oe_o(strb_oe),
        .priority_agent_request_n_i(pri_n),
        .block_next_request_n_i(blk_n), .lock_n_o(lock_n),
        .lock_oe_o(lock_oe)
    );

    chipset_model #(.READ_WORD(RW)) chip_u (
        .ref_clk_i(clk), .resetn_i(rstn), .hold_pri_i(hold_pri),
        .hold_blk_i(hold_blk), .snoop_i(snoop), .snoop_addr_i(snoop_addr),
        .addr_out_i(addr_out), .addr_oe_i(addr_oe),
        .data_out_i(data_out), .data_oe_i(data_oe),
        .strobe_n_i(strb_o), .strobe_oe_i(strb_oe), .addr_o(addr_in),
        .data_o(data_in), .strobe_n_o(strb_in), .pri_n_o(pri_n),
        .blk_n_o(blk_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            final_report();
        end
    endtask

    task automatic do_reset(input logic [3:0] st, input logic ext,
                            input logic [1:0] bs, input int cyc);
        @(posedge clk);
        rstn       <= 1'b0;
        straps     <= st;
        ext_n      <= ext;
        {bs1, bs0} <= bs;
        repeat (cyc) @(posedge clk);
        check("reset", 6'h30,
              {strb_o, lock_n, strb_oe, addr_oe, data_oe, req_oe});
        check("volt", {5'h00, ~VC}, {vlt, vlt_oe});
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        straps     <= ~st;
        ext_n      <= ~ext;
        {bs1, bs0} <= ~bs;
    endtask

    function automatic logic [38:0] bus_now();
        return {addr_oe, req_oe, strb_oe, strb_o, data_oe, req, addr_out};
    endfunction

    // one whole transaction; hold cycles check that the device yields
    task automatic txn(input logic [4:0] code, input logic [31:0] exp_a,
                       input int hold);
        logic [31:0] rd;
        logic        err, wr;
        wr = (code == REQ_IOWR) || (code[2] && code[0]);
        apb(1'b1, ADDR_OFS, A, rd, err);
        apb(1'b1, CMD_OFS, {23'h0, 1'b1, 3'h0, code}, rd, err);
        repeat (hold) begin
            @(posedge clk);
            check("yield", 1'b1, strb_o);
        end
        hold_pri <= 1'b0;
        hold_blk <= 1'b0;
        for (int n = 0; n < 40 && strb_o !== 1'b0; n++) @(posedge clk);
        if (strb_o !== 1'b0) begin
            fail_count++;
            final_report();
        end
        check("req", {5'h1C, code, exp_a[31:3]}, bus_now());
        @(posedge clk);
        check("hold", {5'h1E, code, exp_a[31:3]}, bus_now());
        @(posedge clk);
        check("data drive", wr, data_oe);
        if (wr) check("data out", {WH, WL}, data_out);
        @(posedge clk);
        check("data free", 1'b0, data_oe);
        apb(1'b0, CMD_OFS, 32'h0, rd, err);
        check("idle", 1'b0, rd[CMD_BUSY]);
        if (!wr) begin
            apb(1'b0, RLO_OFS, 32'h0, rd, err);
            check("read lo", RW[31:0], rd);
            apb(1'b0, RHI_OFS, 32'h0, rd, err);
            check("read hi", RW[63:32], rd);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_straps();
        logic [3:0]  pat [13] = '{4'h4, 4'h1, 4'h5, 4'h2, 4'h6, 4'h3, 4'h7,
                                  4'h8, 4'hC, 4'h9, 4'hD, 4'h0, 4'h4};
        logic [31:0] rd;
        logic        err;
        logic [1:0]  bs;
        for (int i = 0; i < 13; i++) begin
            bs = 2'(i % 4);
            do_reset(pat[i], i == 12, bs, 100);
            apb(1'b0, STAT_OFS, 32'h0, rd, err);
            check("ratio", (i < 11) ? 5 + i : 6, rd[3:0]);
            check("strap used", i < 11, rd[STAT_STRAP]);
            check("speed", bs[0] ? 1 + bs[1] : 0, rd[5:4]);
            check("volt code", VC, rd[11:7]);
        end
    endtask

    task automatic t_bus();
        logic [4:0]  codes [9] = '{REQ_DEFER, REQ_INTA, REQ_IORD, REQ_IOWR,
                                   5'h02, 5'h0C, 5'h1E, 5'h15, 5'h0F};
        logic [31:0] rd;
        logic        err;
        apb(1'b1, WLO_OFS, WL, rd, err);
        apb(1'b1, WHI_OFS, WH, rd, err);
        straps[1] <= 1'b0;
        foreach (codes[i]) begin
            if (codes[i][4:1] == 4'h8) txn(codes[i], A & 32'hFFF8, 0);
            else txn(codes[i], A & M20, 0);
        end
        straps[1] <= 1'b1;
        txn(5'h06, A, 0);
        straps[1] <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, CTRL_OFS, 32'h1 << b, rd, err);
            txn(5'h07, (b == CTRL_LOCK) ? A & M20 : A, 0);
            check("lock", (b == CTRL_LOCK) ? 1 : 2, {lock_n, lock_oe});
        end
        apb(1'b1, CTRL_OFS, 32'h0, rd, err);
    endtask

    task automatic t_stall();
        logic [31:0] rd;
        logic        err;
        hold_pri <= 1'b1;
        txn(5'h06, A & M20, 12);
        hold_blk <= 1'b1;
        txn(5'h06, A & M20, 12);
        hold_pri <= 1'b1;
        apb(1'b1, CMD_OFS, 32'h106, rd, err);
        do_reset(4'h4, 1'b0, 2'b01, 100);
        hold_pri <= 1'b0;
        repeat (4) begin
            @(posedge clk);
            check("aborted", 1'b1, strb_o);
        end
        apb(1'b0, CMD_OFS, 32'h0, rd, err);
        check("abort idle", 1'b0, rd[CMD_BUSY]);
    endtask

    task automatic t_misc();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, 8'h40, 32'h0, rd, err);
        check("unmapped", 33'h1_0000_0000, {err, rd});
        apb(1'b1, CMD_OFS, 32'h101, rd, err);
        repeat (6) begin
            @(posedge clk);
            check("reserved", 1'b1, strb_o);
        end
        straps[1]  <= 1'b0;
        snoop_addr <= A[31:3];
        snoop      <= 1'b1;
        @(posedge clk);
        snoop <= 1'b0;
        apb(1'b0, SNOOP_OFS, 32'h0, rd, err);
        check("inquiry", A[31:3], rd[31:3]);
    endtask

    initial begin
        {rstn, psel, penable, pwrite, ext_n, bs0, bs1} = '0;
        {hold_pri, hold_blk, snoop} = '0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        straps     = 4'h0;
        snoop_addr = '0;
        // power-up hold kept short: no clock circuit here to settle
        do_reset(4'h1, 1'b0, 2'b01, 3);
        t_straps();
        t_bus();
        t_stall();
        t_misc();
        final_report();
    end
endmodule
